// *** src/wsc_regs.svh ***
// Register map, field positions, reset values and timing counts of the
// watchdog and sleep control block.
// Assumes a 32-bit APB with byte addresses and a 250 MHz pclk.
`ifndef WSC_REGS_SVH
`define WSC_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define WSC_ADDR_W         12
`define WSC_OFF_CTRL       12'h000
`define WSC_OFF_STAT       12'h004

// ****************************************************************
// Control register fields
// ****************************************************************
`define WSC_CTRL_SWDT      0
`define WSC_CTRL_SINK      1
`define WSC_CTRL_WSEN      2
`define WSC_CTRL_RET       4
`define WSC_CTRL_LVL       5
`define WSC_CTRL_RSLP      7
`define WSC_CTRL_RST       8'h00
`define WSC_CTRL_WMASK     8'h97

// ****************************************************************
// Status register fields
// ****************************************************************
`define WSC_STAT_TO        0
`define WSC_STAT_PD        1
`define WSC_STAT_RUN       2
`define WSC_STAT_W         3

// ****************************************************************
// Timing
// ****************************************************************
`define WSC_CLK_PERIOD_NS  4
`define WSC_WDT_BASE_NS    4000000
`define WSC_WDT_BASE_CYCLES (`WSC_WDT_BASE_NS / `WSC_CLK_PERIOD_NS)
`define WSC_WDT_POST_COUNT 128

`endif

// *** src/wsc_pkg.sv ***
// Types shared by the watchdog and sleep control block.
// Assumes nothing of its surroundings.
package wsc_pkg;

  // Two-bit nonvolatile watchdog setting; low two codes leave the
  // watchdog to software
  typedef enum logic [1:0] {
    WSC_WDT_OFF       = 2'b00,
    WSC_WDT_SOFT      = 2'b01,
    WSC_WDT_HW_NOSLP  = 2'b10,
    WSC_WDT_HW        = 2'b11
  } wsc_wdt_cfg_t;

  // Strap capture sequence
  typedef enum logic {
    WSC_CFG_WAIT,
    WSC_CFG_HELD
  } wsc_cfg_state_t;

endpackage

// *** src/wsc_divider.sv ***
// Enabled modulo counter giving a one-cycle tick every LIMIT enables.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none

module wsc_divider #(
  parameter int unsigned LIMIT = 2
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control
  input  wire logic clear,
  input  wire logic enable,
  // Result
  output logic      tick
);

  localparam int unsigned W = (LIMIT > 2) ? $clog2(LIMIT) : 1;
  localparam logic [W-1:0] LAST = W'(LIMIT - 1);

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;

  // Clear outranks counting so a restart never leaks a stale tick
  always_comb begin
    tick       = enable & ~clear & (count_reg == LAST);
    count_next = count_reg;
    if (clear) begin
      count_next = '0;
    end else if (enable) begin
      count_next = (count_reg == LAST) ? '0 : count_reg + W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

endmodule
`default_nettype wire

// *** src/wsc_top.sv ***
// Watchdog, sleep regulator and wake-up sensing control, APB slave.
// Assumes a zero-wait 32-bit APB master, synchronous core inputs and
// nonvolatile configuration levels stable from reset release.
//
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "wsc_regs.svh"

module wsc_top #(
  parameter int unsigned WDT_BASE_CYCLES = `WSC_WDT_BASE_CYCLES
) (
  // APB slave
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [`WSC_ADDR_W-1:0]     paddr,
  input  wire logic [31:0]                pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // Nonvolatile configuration levels
  input  wire wsc_pkg::wsc_wdt_cfg_t      config_watchdog_enable,
  input  wire logic                       regulator_config_enable,
  input  wire logic                       retention_config_disable,
  // Core events
  input  wire logic                       clear_watchdog_instr,
  input  wire logic                       sleep_instr,
  input  wire logic                       sleep_active,
  input  wire logic                       wake_sense_cmp,
  // Watchdog and power outputs
  output logic                            watchdog_timeout,
  output logic                            watchdog_running,
  output logic                            timeout_flag,
  output logic                            powerdown_flag,
  output logic                            regulator_low_power,
  output logic                            regulator_retention,
  output logic                            wake_sense_enable,
  output logic                            wake_sense_sink_enable
);
  import wsc_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  logic [7:0]     ctrl_reg,  ctrl_next;
  logic           lvl_reg,   lvl_next;
  logic           to_reg,    to_next;
  logic           pd_reg,    pd_next;
  logic           wto_reg,   wto_next;
  logic           run_reg,   run_next;
  logic           rlp_reg,   rlp_next;
  logic           rret_reg,  rret_next;
  logic           wse_reg,   wse_next;
  logic           wsk_reg,   wsk_next;
  logic [31:0]    rdata_reg, rdata_next;
  logic           rdy_reg,   rdy_next;
  logic           err_reg,   err_next;
  wsc_cfg_state_t cfg_st_reg, cfg_st_next;
  wsc_wdt_cfg_t   wcfg_reg,  wcfg_next;
  logic           renv_reg,  renv_next;
  logic           rdis_reg,  rdis_next;

  logic           setup_ph;
  logic           wr_commit;
  logic           hit_ctrl;
  logic           hit_stat;
  logic           wdt_active;
  logic           ret_effective;
  logic           base_tick;
  logic           post_tick;
  logic [7:0]     ctrl_view;
  logic [7:0]     wmask;

  // ****************************************************************
  // Configuration capture
  // ****************************************************************
  // Settings are sampled once after reset release, never under reset
  always_comb begin
    cfg_st_next = cfg_st_reg;
    wcfg_next   = wcfg_reg;
    renv_next   = renv_reg;
    rdis_next   = rdis_reg;
    case (cfg_st_reg)
      WSC_CFG_WAIT: begin
        wcfg_next   = config_watchdog_enable;
        renv_next   = regulator_config_enable;
        rdis_next   = retention_config_disable;
        cfg_st_next = WSC_CFG_HELD;
      end
      WSC_CFG_HELD: begin
        cfg_st_next = WSC_CFG_HELD;
      end
      default: begin
        cfg_st_next = WSC_CFG_WAIT;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_st_reg <= WSC_CFG_WAIT;
      wcfg_reg   <= WSC_WDT_OFF;
      renv_reg   <= 1'b0;
      rdis_reg   <= 1'b1;
    end else begin
      cfg_st_reg <= cfg_st_next;
      wcfg_reg   <= wcfg_next;
      renv_reg   <= renv_next;
      rdis_reg   <= rdis_next;
    end
  end

  // ****************************************************************
  // Watchdog timing
  // ****************************************************************
  // Code 11 runs the timer outright, code 10 only outside sleep; the low codes defer to bit 0
  always_comb begin
    case (wcfg_reg)
      WSC_WDT_HW:       wdt_active = 1'b1;
      WSC_WDT_HW_NOSLP: wdt_active = ~sleep_active;
      default:          wdt_active = ctrl_reg[`WSC_CTRL_SWDT];
    endcase
  end

  wsc_divider #(
    .LIMIT  (WDT_BASE_CYCLES)
  ) u_base (
    .clk    (pclk),
    .rst_n  (presetn),
    .clear  (clear_watchdog_instr),
    .enable (wdt_active),
    .tick   (base_tick)
  );

  wsc_divider #(
    .LIMIT  (`WSC_WDT_POST_COUNT)
  ) u_post (
    .clk    (pclk),
    .rst_n  (presetn),
    .clear  (clear_watchdog_instr),
    .enable (base_tick),
    .tick   (post_tick)
  );

  // ****************************************************************
  // APB decode
  // ****************************************************************
  // Answer is prepared in the setup cycle so pready can be a flop
  assign setup_ph  = psel & ~penable;
  assign wr_commit = psel & penable & rdy_reg & pwrite & ~err_reg;
  assign hit_ctrl  = (paddr == `WSC_OFF_CTRL);
  assign hit_stat  = (paddr == `WSC_OFF_STAT);
  assign wmask     = `WSC_CTRL_WMASK & {8{pstrb[0]}};

  // Comparator bit reads zero while sensing is off
  always_comb begin
    ctrl_view = ctrl_reg;
    ctrl_view[`WSC_CTRL_LVL] = lvl_reg & ctrl_reg[`WSC_CTRL_WSEN];
  end

  // ****************************************************************
  // Register and flag next state
  // ****************************************************************
  always_comb begin
    ctrl_next  = ctrl_reg;
    lvl_next   = wake_sense_cmp;
    to_next    = to_reg;
    pd_next    = pd_reg;
    rdy_next   = setup_ph;
    err_next   = setup_ph & ~(hit_ctrl | hit_stat);
    rdata_next = rdata_reg;
    if (setup_ph) begin
      rdata_next = 32'h0000_0000;
      if (!pwrite && hit_ctrl) begin
        rdata_next[7:0] = ctrl_view;
      end else if (!pwrite && hit_stat) begin
        rdata_next[`WSC_STAT_TO]  = to_reg;
        rdata_next[`WSC_STAT_PD]  = pd_reg;
        rdata_next[`WSC_STAT_RUN] = run_reg;
      end
    end
    // Writable bits only; the comparator bit cannot be written
    if (wr_commit && hit_ctrl) begin
      ctrl_next = (ctrl_reg & ~wmask) | (pwdata[7:0] & wmask);
    end
    if (sleep_instr) begin
      pd_next = 1'b0;
      to_next = 1'b1;
    end
    if (clear_watchdog_instr) begin
      to_next = 1'b1;
      pd_next = 1'b1;
    end
    // A time-out in the same cycle as a sleep wins; a clear suppresses the time-out
    if (post_tick) begin
      to_next = 1'b0;
    end
  end

  // ****************************************************************
  // Output next state
  // ****************************************************************
  assign ret_effective = ctrl_reg[`WSC_CTRL_RET] & renv_reg
                       & ~rdis_reg;

  always_comb begin
    wto_next  = post_tick;
    run_next  = wdt_active;
    rret_next = sleep_active & ret_effective;
    // Without retention the regulator stays on; bit 7 picks low power
    rlp_next  = sleep_active & ~ret_effective
              & ctrl_reg[`WSC_CTRL_RSLP];
    wse_next  = ctrl_reg[`WSC_CTRL_WSEN];
    wsk_next  = ctrl_reg[`WSC_CTRL_WSEN] & ctrl_reg[`WSC_CTRL_SINK];
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Flags come up as after power-on: both set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg  <= `WSC_CTRL_RST;
      lvl_reg   <= 1'b0;
      to_reg    <= 1'b1;
      pd_reg    <= 1'b1;
      rdata_reg <= 32'h0000_0000;
      rdy_reg   <= 1'b0;
      err_reg   <= 1'b0;
      wto_reg   <= 1'b0;
      run_reg   <= 1'b0;
      rlp_reg   <= 1'b0;
      rret_reg  <= 1'b0;
      wse_reg   <= 1'b0;
      wsk_reg   <= 1'b0;
    end else begin
      ctrl_reg  <= ctrl_next;
      lvl_reg   <= lvl_next;
      to_reg    <= to_next;
      pd_reg    <= pd_next;
      rdata_reg <= rdata_next;
      rdy_reg   <= rdy_next;
      err_reg   <= err_next;
      wto_reg   <= wto_next;
      run_reg   <= run_next;
      rlp_reg   <= rlp_next;
      rret_reg  <= rret_next;
      wse_reg   <= wse_next;
      wsk_reg   <= wsk_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata                 = rdata_reg;
  assign pready                 = rdy_reg;
  assign pslverr                = err_reg;
  assign watchdog_timeout       = wto_reg;
  assign watchdog_running       = run_reg;
  assign timeout_flag           = to_reg;
  assign powerdown_flag         = pd_reg;
  assign regulator_low_power    = rlp_reg;
  assign regulator_retention    = rret_reg;
  assign wake_sense_enable      = wse_reg;
  assign wake_sense_sink_enable = wsk_reg;

endmodule
`default_nettype wire

// *** bench/wsc_top_chk.sv ***
// Checker for the watchdog and sleep control block, bound to wsc_top.
// Assumes config levels held stable between resets by the bench.
`timescale 1ns/1ps
`default_nettype none
`include "wsc_regs.svh"

module wsc_top_chk (
  // Clock, reset and bus
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [`WSC_ADDR_W-1:0] paddr,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  // Config levels and core events
  input wire logic                   regulator_config_enable,
  input wire logic                   retention_config_disable,
  input wire logic                   clear_watchdog_instr,
  input wire logic                   sleep_instr,
  // Watchdog and power outputs
  input wire logic                   watchdog_timeout,
  input wire logic                   watchdog_running,
  input wire logic                   timeout_flag,
  input wire logic                   powerdown_flag,
  input wire logic                   regulator_low_power,
  input wire logic                   regulator_retention,
  input wire logic                   wake_sense_enable,
  input wire logic                   wake_sense_sink_enable
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  // All checks share one domain, so reset disables them in one place
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_ready_next;
    psel && !penable |=> pready;
  endproperty
  a_ready_next: assert property (p_ready_next)
    else $error("no answer after setup");
  property p_ready_only;
    pready |-> psel && penable;
  endproperty
  a_ready_only: assert property (p_ready_only)
    else $error("answer outside access");
  property p_err_map;
    pready && paddr != 12'h000 && paddr != 12'h004 |-> pslverr;
  endproperty
  a_err_map: assert property (p_err_map)
    else $error("unmapped access without error");
  property p_upper_zero;
    pready && !pwrite |-> prdata[31:8] == 24'h000000;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper read bits not zero");
  property p_lvl_gated;
    pready && !pwrite && paddr == 12'h000 && !wake_sense_enable
      |-> !prdata[5];
  endproperty
  a_lvl_gated: assert property (p_lvl_gated)
    else $error("level bit set with sensing off");
  property p_sink_gated;
    wake_sense_sink_enable |-> wake_sense_enable;
  endproperty
  a_sink_gated: assert property (p_sink_gated)
    else $error("sink on without sensing");
  // The clear suppresses any time-out in its own cycle
  property p_clear_flags;
    clear_watchdog_instr && !sleep_instr && !watchdog_timeout
      |=> timeout_flag && powerdown_flag;
  endproperty
  a_clear_flags: assert property (p_clear_flags)
    else $error("clear did not set both flags");
  property p_timeout_flag;
    watchdog_timeout |=> !timeout_flag ##1 !watchdog_timeout;
  endproperty
  a_timeout_flag: assert property (p_timeout_flag)
    else $error("time-out flag or pulse wrong");
  property p_ret_gate;
    regulator_retention |-> regulator_config_enable
      && !retention_config_disable;
  endproperty
  a_ret_gate: assert property (p_ret_gate)
    else $error("retention despite config");
  // Low power only applies when retention is not in effect
  property p_lp_excl;
    regulator_low_power |-> !regulator_retention;
  endproperty
  a_lp_excl: assert property (p_lp_excl)
    else $error("low power and retention together");
  property p_timeout_run;
    watchdog_timeout |-> $past(watchdog_running);
  endproperty
  a_timeout_run: assert property (p_timeout_run)
    else $error("time-out while stopped");
endmodule

bind wsc_top wsc_top_chk wsc_top_chk_inst (.*);
`default_nettype wire

// *** bench/watchdog_sleep_control_bench.sv ***
// Self-checking bench for the watchdog and sleep control block.
// Assumes the design sources and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "wsc_regs.svh"

module watchdog_sleep_control_bench;
  import wsc_pkg::*;
  // Short base count keeps a time-out at a few hundred cycles
  localparam int WDT_CYC = 4;
  localparam int PERIOD  = WDT_CYC * `WSC_WDT_POST_COUNT;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [`WSC_ADDR_W-1:0] paddr;
  logic [31:0]  pwdata, prdata;
  logic [3:0]   pstrb;
  wsc_wdt_cfg_t config_watchdog_enable;
  logic regulator_config_enable, retention_config_disable;
  logic clear_watchdog_instr, sleep_instr, sleep_active, wake_sense_cmp;
  logic watchdog_timeout, watchdog_running, timeout_flag, powerdown_flag;
  logic regulator_low_power, regulator_retention;
  logic wake_sense_enable, wake_sense_sink_enable;
  int   fails, n_checks;

  wsc_top #(.WDT_BASE_CYCLES(WDT_CYC)) wsc_top_inst (.*);

  // ****************************************************************
  // Clock and shared tasks
  // ****************************************************************
  initial begin
    pclk = 0;
    forever #2 pclk = ~pclk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One APB transfer; the idle edge first keeps drivers single per step
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int i;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      fails++;
      give_verdict();
    end
    r = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask

  task automatic wr(logic [11:0] a, logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1, a, d, r, e);
    repeat (3) @(posedge pclk);
  endtask

  task automatic rd(string nm, logic [11:0] a, logic [31:0] x, logic xe);
    logic [31:0] r;
    logic e;
    apb(0, a, 32'h0, r, e);
    chk(nm, x, r);
    chk({nm, "_err"}, {31'h0, xe}, {31'h0, e});
  endtask

  // Bounded wait for the time-out pulse; running out ends the run
  task automatic wait_wto(output int n);
    n = 0;
    while (watchdog_timeout !== 1'b1 && n < PERIOD + 100) begin
      @(posedge pclk);
      n++;
    end
    if (watchdog_timeout !== 1'b1) begin
      fails++;
      give_verdict();
    end
  endtask

  task automatic do_reset(wsc_wdt_cfg_t c, logic re, logic rd_);
    presetn <= 0; config_watchdog_enable <= c;
    regulator_config_enable <= re; retention_config_disable <= rd_;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    repeat (2) @(posedge pclk);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs();
    do_reset(WSC_WDT_OFF, 0, 1);
    rd("ctrl_rst", `WSC_OFF_CTRL, 32'h0, 0);
    rd("stat_rst", `WSC_OFF_STAT, 32'h3, 0);
    wr(`WSC_OFF_CTRL, 32'hff);
    rd("ctrl_rw", `WSC_OFF_CTRL, 32'h97, 0);
    wake_sense_cmp <= 1;
    rd("ctrl_lvl", `WSC_OFF_CTRL, 32'hb7, 0);
    chk("sink", 32'h1, {31'h0, wake_sense_sink_enable});
    chk("wse_on", 32'h1, {31'h0, wake_sense_enable});
    wr(`WSC_OFF_CTRL, 32'h02);
    rd("lvl_off", `WSC_OFF_CTRL, 32'h02, 0);
    chk("wse_off", 32'h0, {31'h0, wake_sense_enable});
    chk("sink_off", 32'h0, {31'h0, wake_sense_sink_enable});
    // Byte lane 0 off: the write must leave the word alone
    pstrb <= 4'he;
    wr(`WSC_OFF_CTRL, 32'h00);
    rd("strb_off", `WSC_OFF_CTRL, 32'h02, 0);
    pstrb <= 4'hf;
    rd("unmapped", 12'h008, 32'h0, 1);
    wake_sense_cmp <= 0;
  endtask

  // Soft watchdog: sleep clears PD, time-out clears TO, clear sets both
  task automatic t_soft_wdt();
    int n;
    do_reset(WSC_WDT_SOFT, 0, 1);
    wr(`WSC_OFF_CTRL, 32'h01);
    sleep_instr <= 1;
    @(posedge pclk);
    sleep_instr <= 0;
    repeat (2) @(posedge pclk);
    chk("pd_sleep", 32'h0, {31'h0, powerdown_flag});
    wait_wto(n);
    chk("period", 32'h1, {31'h0, n > PERIOD - 12 && n < PERIOD + 4});
    repeat (2) @(posedge pclk);
    chk("to_out", 32'h0, {31'h0, timeout_flag});
    clear_watchdog_instr <= 1;
    @(posedge pclk);
    clear_watchdog_instr <= 0;
    @(posedge pclk);
    chk("clr_flags", 32'h3, {30'h0, powerdown_flag, timeout_flag});
    // Clear zeroed both stages, so a whole period runs from it
    wait_wto(n);
    chk("clr_period", PERIOD, n);
  endtask

  // Enabled config codes override the software bit
  task automatic t_cfg_wdt();
    for (int c = 0; c < 4; c++) begin
      do_reset(wsc_wdt_cfg_t'(c), 0, 1);
      wr(`WSC_OFF_CTRL, 32'h00);
      chk("run_off", {31'h0, c >= 2}, {31'h0, watchdog_running});
      wr(`WSC_OFF_CTRL, 32'h01);
      chk("run_on", 32'h1, {31'h0, watchdog_running});
      // Code 10 pauses the timer while the core sleeps
      sleep_active <= 1;
      repeat (3) @(posedge pclk);
      chk("run_slp", {31'h0, c != 2}, {31'h0, watchdog_running});
      sleep_active <= 0;
    end
  endtask

  // Retention gated by both config bits; bit 7 picks low power in sleep
  task automatic t_regulator();
    for (int c = 0; c < 4; c++) begin
      do_reset(WSC_WDT_OFF, c[1], c[0]);
      sleep_active <= 1;
      wr(`WSC_OFF_CTRL, 32'h10);
      chk("ret", {31'h0, c == 2}, {31'h0, regulator_retention});
      wr(`WSC_OFF_CTRL, 32'h80);
      chk("lp_on", 32'h1, {31'h0, regulator_low_power});
      chk("ret_off", 32'h0, {31'h0, regulator_retention});
      wr(`WSC_OFF_CTRL, 32'h00);
      chk("lp_off", 32'h0, {31'h0, regulator_low_power});
      sleep_active <= 0;
    end
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    fails = 0; n_checks = 0;
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0;
    pwdata = '0; pstrb = 4'hf; config_watchdog_enable = WSC_WDT_OFF;
    regulator_config_enable = 0; retention_config_disable = 1;
    clear_watchdog_instr = 0; sleep_instr = 0; sleep_active = 0;
    wake_sense_cmp = 0;
    t_regs();
    t_soft_wdt();
    t_cfg_wdt();
    t_regulator();
    give_verdict();
  end
endmodule
`default_nettype wire
